// ===== core/data_block_window_unit.sv
// data block window: relative access, bound check and window shift
`timescale 1ns/1ns
module data_block_window_unit (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // request from instruction execution
    input wire window_pkg::req_type i_req,
    // answer to instruction execution
    output window_pkg::resp_type o_resp,
    // current window for observation
    output logic [window_pkg::ADDR_W-1:0] o_base,
    output logic [window_pkg::LEN_W-1:0] o_len
);
    typedef struct packed {
        window_pkg::resp_type resp;
        logic [window_pkg::ADDR_W-1:0] base;
        logic [window_pkg::LEN_W-1:0] len;
    } state_type;

    state_type state_reg;
    state_type state_next;
    logic [window_pkg::ADDR_W-1:0] cur_base;
    logic [window_pkg::LEN_W-1:0] cur_len;
    logic do_load;
    logic do_shift;
    logic [window_pkg::LEN_W-1:0] load_len;
    logic shift_ok;
    logic access_ok;

    // clamp a requested length to at most MAX_LEN (4091 words)
    function automatic logic [window_pkg::LEN_W-1:0] clamp_len(
        input logic [window_pkg::WORD_W-1:0] len);
        if (len > {4'h0, window_pkg::MAX_LEN}) begin
            clamp_len = window_pkg::MAX_LEN;
        end else begin
            clamp_len = len[window_pkg::LEN_W-1:0];
        end
    endfunction

    // word number below length, shared by access and shift checks
    function automatic logic below_len(
        input logic [window_pkg::WORD_W-1:0] num,
        input logic [window_pkg::LEN_W-1:0] len);
        below_len = num < {4'h0, len};
    endfunction

    // decode of the request against the current window
    always_comb begin
        load_len = clamp_len(i_req.open_len);
        do_load = i_req.valid && (i_req.op == window_pkg::OP_OPEN);
        // zero length means nothing open, so shift fails too
        shift_ok = (cur_len != window_pkg::LEN_RESET)
            && below_len(i_req.accu_one_low, cur_len);
        do_shift = i_req.valid && (i_req.op == window_pkg::OP_SHIFT)
            && shift_ok;
        access_ok = (i_req.word_num <= window_pkg::MAX_DIRECT_WORD)
            && below_len(i_req.word_num, cur_len);
    end

    window_regs u_regs (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_load(do_load),
        .i_shift(do_shift),
        .i_base(i_req.open_base),
        .i_len(load_len),
        .i_offset(i_req.accu_one_low[window_pkg::LEN_W-1:0]),
        .o_base(cur_base),
        .o_len(cur_len)
    );

    // answer one cycle after the request; window mirrors regs
    always_comb begin
        state_next = state_reg;
        state_next.base = do_load ? i_req.open_base : cur_base;
        state_next.len = cur_len;
        state_next.resp = '0;
        if (do_load) begin
            state_next.len = load_len;
        end else if (do_shift) begin
            state_next.base = cur_base
                + {4'h0, i_req.accu_one_low[window_pkg::LEN_W-1:0]};
            state_next.len = cur_len
                - i_req.accu_one_low[window_pkg::LEN_W-1:0];
        end
        if (i_req.valid) begin
            state_next.resp.done = 1'b1;
            case (i_req.op)
                window_pkg::OP_OPEN: begin
                    state_next.resp.logic_result_bit = 1'b0;
                end
                window_pkg::OP_SHIFT: begin
                    state_next.resp.logic_result_bit = !shift_ok;
                    state_next.resp.codes_clear = 1'b1;
                end
                window_pkg::OP_ACCESS: begin
                    state_next.resp.access_ok = access_ok;
                    state_next.resp.logic_result_bit = !access_ok;
                    // address formed even on error; caller drops it
                    state_next.resp.access_addr = cur_base
                        + i_req.word_num;
                end
                default: begin
                    state_next.resp.done = 1'b0;
                end
            endcase
        end
    end

    // register all state
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_resp = state_reg.resp;
    assign o_base = state_reg.base;
    assign o_len = state_reg.len;
endmodule // data_block_window_unit

// ===== core/window_pkg.sv
// package with constants and carrier types for the data block window unit
package window_pkg;
    localparam int ADDR_W = 16;
    localparam int LEN_W = 12;
    localparam int WORD_W = 16;
    localparam logic [LEN_W-1:0] MAX_LEN = 12'hffb; // 4091 words
    localparam logic [WORD_W-1:0] MAX_DIRECT_WORD = 16'h00ff; // 255
    localparam logic [ADDR_W-1:0] BASE_RESET = 16'h0000;
    localparam logic [LEN_W-1:0] LEN_RESET = 12'h000;

    // operation codes issued by instruction execution
    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_OPEN = 2'h1,
        OP_ACCESS = 2'h3,
        OP_SHIFT = 2'h2
    } op_type;

    // request from instruction execution
    typedef struct packed {
        logic valid;
        op_type op;
        logic extended;
        logic [ADDR_W-1:0] open_base;
        logic [WORD_W-1:0] open_len;
        logic [WORD_W-1:0] word_num;
        logic [WORD_W-1:0] accu_one_low;
    } req_type;

    // answer to instruction execution
    typedef struct packed {
        logic done;
        logic logic_result_bit;
        logic codes_clear;
        logic access_ok;
        logic [ADDR_W-1:0] access_addr;
    } resp_type;
endpackage

// ===== core/window_regs.sv
// base and length register pair with open and shift update
`timescale 1ns/1ns
module window_regs (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // update controls
    input wire logic i_load,
    input wire logic i_shift,
    input wire logic [window_pkg::ADDR_W-1:0] i_base,
    input wire logic [window_pkg::LEN_W-1:0] i_len,
    input wire logic [window_pkg::LEN_W-1:0] i_offset,
    // current contents
    output logic [window_pkg::ADDR_W-1:0] o_base,
    output logic [window_pkg::LEN_W-1:0] o_len
);
    typedef struct packed {
        logic [window_pkg::ADDR_W-1:0] block_base_register;
        logic [window_pkg::LEN_W-1:0] block_length_register;
    } regs_type;

    regs_type state_reg;
    regs_type state_next;

    // open has priority; it undoes earlier shifts
    always_comb begin
        state_next = state_reg;
        if (i_load) begin
            state_next.block_base_register = i_base;
            state_next.block_length_register = i_len;
        end else if (i_shift) begin
            // unsigned 16-bit add, wraps at top of memory
            state_next.block_base_register = state_reg.block_base_register
                + {4'h0, i_offset};
            state_next.block_length_register =
                state_reg.block_length_register - i_offset;
        end
    end

    // register the state copy
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg.block_base_register <= window_pkg::BASE_RESET;
            state_reg.block_length_register <= window_pkg::LEN_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_base = state_reg.block_base_register;
    assign o_len = state_reg.block_length_register;
endmodule // window_regs

// ===== verification/exec_model.sv
// instruction execution model issuing block operations
`timescale 1ns/1ns
module exec_model (
    // clock
    input wire logic i_clk,
    // request to the window unit
    output window_pkg::req_type o_req
);
    initial o_req = '0;
    // one-cycle request; idle fields inverted so stale values never help
    task automatic issue(input logic [1:0] op, input logic [15:0] a,
            input logic [15:0] b);
        @(posedge i_clk);
        o_req <= '{1'b1, window_pkg::op_type'(op), a[4], a, b, a, b};
        @(posedge i_clk);
        o_req <= '{1'b0, window_pkg::OP_NONE, 1'b0, ~a, ~b, ~a, ~b};
        #1;
    endtask
endmodule // exec_model

// ===== verification/tb_data_block_window_unit.sv
// testbench for the data block window unit
`timescale 1ns/1ns
module tb_data_block_window_unit;
    localparam logic [1:0] OPN = 2'h1, SHF = 2'h2, ACC = 2'h3;
    logic i_clk, i_rst_n;
    window_pkg::req_type i_req;
    window_pkg::resp_type o_resp;
    logic [15:0] o_base;
    logic [11:0] o_len;
    logic [29:0] st;
    logic [17:0] ac;
    int err_total = 0, checked = 0, cyc = 0;
    // compact views of window state and access answer
    assign st = {o_resp.done, o_resp.logic_result_bit, o_base, o_len};
    assign ac = {o_resp.access_ok, o_resp.logic_result_bit,
        o_resp.access_addr};
    data_block_window_unit i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_req(i_req), .o_resp(o_resp), .o_base(o_base), .o_len(o_len));
    exec_model i_exec (.i_clk(i_clk), .o_req(i_req));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic t_shift();
        i_exec.issue(OPN, 16'h151b, 16'h0008);
        chk(st, {2'b10, 16'h151b, 12'h008});
        i_exec.issue(SHF, 16'h0, 16'h0002);
        chk(st, {2'b10, 16'h151d, 12'h006});
        chk(o_resp.codes_clear, 1'b1);
        i_exec.issue(ACC, 16'h0005, 16'h0);
        chk(ac, {2'b10, 16'h1522});
        i_exec.issue(ACC, 16'h0006, 16'h0);
        chk(ac[17:16], 2'b01);
        i_exec.issue(SHF, 16'h0, 16'h0001);
        chk(st, {2'b10, 16'h151e, 12'h005});
        i_exec.issue(SHF, 16'h0, 16'h0005);
        chk(st, {2'b11, 16'h151e, 12'h005});
        i_exec.issue(OPN, 16'h151b, 16'h0008);
        chk(st, {2'b10, 16'h151b, 12'h008});
    endtask
    task automatic t_limits();
        i_exec.issue(OPN, 16'h0, 16'h0000);
        i_exec.issue(SHF, 16'h0, 16'h0000);
        chk(st, {2'b11, 16'h0000, 12'h000});
        i_exec.issue(OPN, 16'h2000, 16'h1004);
        chk(o_len, 12'hffb);
        i_exec.issue(ACC, 16'h0100, 16'h0);
        chk(ac[17:16], 2'b01);
        // long block reached past word 255 through a shift; the address wraps past the top of memory
        i_exec.issue(OPN, 16'hfff0, 16'h0102);
        i_exec.issue(SHF, 16'h0, 16'h0002);
        chk(st, {2'b10, 16'hfff2, 12'h100});
        i_exec.issue(ACC, 16'h00ff, 16'h0);
        chk(ac, {2'b10, 16'h00f1});
        // valid with no operation: no answer, window untouched
        i_exec.issue(2'h0, 16'h0, 16'h0001);
        chk(st, {2'b00, 16'hfff2, 12'h100});
    endtask
    initial begin
        i_rst_n = 1'b0;
        repeat (16) @(posedge i_clk);
        chk(st, 32'h0);
        i_rst_n <= 1'b1;
        t_shift();
        t_limits();
        stop_test();
    end
    // hang guard, far above the few dozen cycles needed
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            stop_test();
        end
    end
endmodule // tb_data_block_window_unit
bind data_block_window_unit window_monitor i_mon (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_req(i_req), .o_resp(o_resp), .o_base(o_base),
    .o_len(o_len));

// ===== verification/window_monitor.sv
// port checker for the data block window unit
`timescale 1ns/1ns
module window_monitor (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // request and answer
    input wire window_pkg::req_type i_req,
    input wire window_pkg::resp_type o_resp,
    input wire logic [15:0] o_base,
    input wire logic [11:0] o_len
);
    logic op_o, op_s, op_a, bad;
    // decoded requests, so each property stays short
    assign op_o = i_req.valid && i_req.op == window_pkg::OP_OPEN;
    assign op_s = i_req.valid && i_req.op == window_pkg::OP_SHIFT;
    assign op_a = i_req.valid && i_req.op == window_pkg::OP_ACCESS;
    assign bad = i_req.word_num > 16'h00ff || i_req.word_num >= o_len;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    AST_OPEN: assert property (op_o && i_req.open_len < 16'h0ffc |=>
        o_base == $past(i_req.open_base) && o_len == $past(i_req.open_len))
        else $error("open did not load window");
    AST_CLAMP: assert property (op_o && i_req.open_len > 16'h0ffb |=>
        o_len == 12'hffb) else $error("long open not clamped");
    AST_ADDR: assert property (op_a |=>
        o_resp.access_addr == $past(o_base) + $past(i_req.word_num))
        else $error("access address wrong");
    AST_ACC_ERR: assert property (op_a && bad |=>
        !o_resp.access_ok && o_resp.logic_result_bit)
        else $error("bad access accepted");
    AST_ACC_OK: assert property (op_a && !bad |=>
        o_resp.access_ok && !o_resp.logic_result_bit)
        else $error("good access refused");
    AST_SHIFT: assert property (op_s && i_req.accu_one_low < o_len |=>
        o_base == $past(o_base) + $past(i_req.accu_one_low) &&
        o_len == $past(o_len) - $past(i_req.accu_one_low) &&
        !o_resp.logic_result_bit && o_resp.codes_clear)
        else $error("shift result wrong");
    AST_SHIFT_ERR: assert property (op_s && i_req.accu_one_low >= o_len |=>
        $stable(o_base) && $stable(o_len) && o_resp.logic_result_bit &&
        o_resp.codes_clear) else $error("bad shift not refused");
    AST_HOLD: assert property (!(op_o || op_s) |=>
        $stable(o_base) && $stable(o_len)) else $error("window moved");
    AST_DONE: assert property (i_req.valid && i_req.op != window_pkg::OP_NONE
        |=> o_resp.done) else $error("answer missing");
    // main scenarios reached
    cover property (op_s && i_req.accu_one_low < o_len);
    cover property (op_s && i_req.accu_one_low >= o_len);
    cover property (op_a && bad);
endmodule // window_monitor
